// ==== core/break_unit_pkg.sv ====
package break_unit_pkg;

  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int COUNT_W = 16;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0001;

  // bus-state class select
  localparam logic [1:0] CLASS_ALL  = 2'h0;
  localparam logic [1:0] CLASS_DATA = 2'h1;
  localparam logic [1:0] CLASS_XFER = 2'h2;

  // direction select
  localparam logic [1:0] DIR_ANY   = 2'h0;
  localparam logic [1:0] DIR_READ  = 2'h1;
  localparam logic [1:0] DIR_WRITE = 2'h2;

  // address mode select
  localparam logic [1:0] AMODE_OFF   = 2'h0;
  localparam logic [1:0] AMODE_EQ    = 2'h1;
  localparam logic [1:0] AMODE_RANGE = 2'h2;

  // access size select / bus size code
  localparam logic [1:0] SIZE_ANY  = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;

  // emulation mode
  localparam logic [2:0] EMODE_NORMAL  = 3'h0;
  localparam logic [2:0] EMODE_SEQ1    = 3'h1;
  localparam logic [2:0] EMODE_SEQ2    = 3'h2;
  localparam logic [2:0] EMODE_SEQ3    = 3'h3;
  localparam logic [2:0] EMODE_TIMEOUT = 3'h4;

  // register map (word index = byte address / 4)
  localparam int NUM_CH = 4;
  localparam logic [7:0] REG_MODE     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_COUNT    = 8'h08;
  localparam logic [7:0] REG_RSTPT    = 8'h0c;
  localparam logic [7:0] REG_CH_BASE  = 8'h40;
  localparam int         CH_STRIDE_SH = 5;
  // per-channel word offsets inside a 32-byte slot
  localparam logic [2:0] CH_CTRL  = 3'h0;
  localparam logic [2:0] CH_ASTRT = 3'h1;
  localparam logic [2:0] CH_AEND  = 3'h2;
  localparam logic [2:0] CH_AMASK = 3'h3;
  localparam logic [2:0] CH_DVAL  = 3'h4;
  localparam logic [2:0] CH_DMASK = 3'h5;

  // mode register fields
  localparam int MODE_EMODE_LSB = 0;
  localparam int MODE_OVFBRK    = 4;
  localparam int MODE_CNTEN     = 5;
  localparam int MODE_RSTPT_EN  = 6;

  // channel control fields
  localparam int CTL_AMODE_LSB = 0;
  localparam int CTL_AMASKEN   = 2;
  localparam int CTL_DEN       = 3;
  localparam int CTL_DMASKEN   = 4;
  localparam int CTL_SIZE_LSB  = 5;
  localparam int CTL_CLASS_LSB = 7;
  localparam int CTL_DIR_LSB   = 9;
  localparam int CTL_W         = 11;

endpackage

// ==== core/match_channel.sv ====
`timescale 1ns/1ps
// one bus-cycle comparator; range allowed only when the parameter says so
module match_channel #(
  parameter bit RANGE_OK = 1'b0
) (
  input  wire logic                                clk_in,
  input  wire logic                                rst_b_in,
  input  wire logic [break_unit_pkg::CTL_W-1:0]    ctrl_in,
  input  wire logic                                range_block_in,
  input  wire logic [break_unit_pkg::ADDR_W-1:0]   a_start_in,
  input  wire logic [break_unit_pkg::ADDR_W-1:0]   a_end_in,
  input  wire logic [break_unit_pkg::ADDR_W-1:0]   a_mask_in,
  input  wire logic [break_unit_pkg::DATA_W-1:0]   d_val_in,
  input  wire logic [break_unit_pkg::DATA_W-1:0]   d_mask_in,
  input  wire logic                                cyc_in,
  input  wire logic [break_unit_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [break_unit_pkg::DATA_W-1:0]   data_in,
  input  wire logic                                wr_in,
  input  wire logic                                xfer_in,
  input  wire logic [1:0]                          size_in,
  output logic                                     hit_out
);

  typedef struct packed {
    logic hit;
  } ch_state_t;

  ch_state_t st_reg;
  ch_state_t st_next;

  logic [1:0] amode;
  logic [1:0] cls;
  logic [1:0] dir;
  logic [1:0] sz;
  logic       a_ok;
  logic       d_ok;
  logic       c_ok;
  logic       r_ok;
  logic       s_ok;

  assign amode = ctrl_in[break_unit_pkg::CTL_AMODE_LSB +: 2];
  assign cls   = ctrl_in[break_unit_pkg::CTL_CLASS_LSB +: 2];
  assign dir   = ctrl_in[break_unit_pkg::CTL_DIR_LSB +: 2];
  assign sz    = ctrl_in[break_unit_pkg::CTL_SIZE_LSB +: 2];

  always_comb begin
    logic [break_unit_pkg::ADDR_W-1:0] am;
    logic [break_unit_pkg::DATA_W-1:0] dm;
    am = ctrl_in[break_unit_pkg::CTL_AMASKEN] ? a_mask_in : '0;
    dm = ctrl_in[break_unit_pkg::CTL_DMASKEN] ? d_mask_in : '0;
    case (amode)
      break_unit_pkg::AMODE_OFF:   a_ok = 1'b1;
      break_unit_pkg::AMODE_EQ:    a_ok = ((addr_in ^ a_start_in) & ~am) == '0;
      break_unit_pkg::AMODE_RANGE: a_ok = RANGE_OK && !range_block_in &&
                                          addr_in >= a_start_in && addr_in <= a_end_in;
      default:                     a_ok = 1'b0;
    endcase
    d_ok = !ctrl_in[break_unit_pkg::CTL_DEN] || (((data_in ^ d_val_in) & ~dm) == '0);
    s_ok = (sz == break_unit_pkg::SIZE_ANY) || (sz == size_in);
    case (cls)
      break_unit_pkg::CLASS_ALL:  c_ok = 1'b1;
      break_unit_pkg::CLASS_DATA: c_ok = !xfer_in;
      break_unit_pkg::CLASS_XFER: c_ok = xfer_in;
      default:                    c_ok = 1'b0;
    endcase
    case (dir)
      break_unit_pkg::DIR_ANY:   r_ok = 1'b1;
      break_unit_pkg::DIR_READ:  r_ok = !wr_in;
      break_unit_pkg::DIR_WRITE: r_ok = wr_in;
      default:                   r_ok = 1'b0;
    endcase
    st_next.hit = cyc_in && a_ok && d_ok && s_ok && c_ok && r_ok;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hit_out = st_reg.hit;

endmodule

// ==== core/break_unit.sv ====
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module break_unit (
  input  wire logic                              CLK_IN,
  input  wire logic                              RST_B_IN,
  // register port
  input  wire logic [7:0]                        REG_ADDR_IN,
  input  wire logic [31:0]                       REG_WDATA_IN,
  input  wire logic                              REG_WR_IN,
  input  wire logic                              REG_RD_IN,
  output logic [31:0]                            REG_RDATA_OUT,
  // run control
  input  wire logic                              RUN_START_IN,
  input  wire logic                              HOST_STOP_IN,
  input  wire logic                              SW_BREAK_IN,
  input  wire logic                              TRACE_HALT_IN,
  input  wire logic                              TRACE_OVF_IN,
  input  wire logic                              PERF_TIMEOUT_IN,
  // target bus, compared unregistered; each channel registers its own hit (same clock as emulator bus sampler)
  input  wire logic                              BUS_CYC_IN,
  input  wire logic [break_unit_pkg::ADDR_W-1:0] BUS_ADDR_IN,
  input  wire logic [break_unit_pkg::DATA_W-1:0] BUS_DATA_IN,
  input  wire logic                              BUS_WR_IN,
  input  wire logic                              BUS_XFER_IN,
  input  wire logic [1:0]                        BUS_SIZE_IN,
  output logic                                   BREAK_OUT,
  output logic                                   TRACE_RELEASE_OUT,
  output logic                                   RUNNING_OUT
);

  localparam int NCH = break_unit_pkg::NUM_CH;

  typedef enum {SEQ_IDLE, SEQ_WAIT4, SEQ_WAIT3, SEQ_WAIT2, SEQ_WAIT1} seq_t;

  typedef struct packed {
    logic [2:0]                                   emode;
    logic                                         ovf_en;
    logic                                         cnt_en;
    logic                                         rstpt_en;
    logic [break_unit_pkg::COUNT_W-1:0]           count_set;
    logic [break_unit_pkg::COUNT_W-1:0]           count_left;
    logic [break_unit_pkg::ADDR_W-1:0]            rstpt;
    logic [NCH-1:0][break_unit_pkg::CTL_W-1:0]    ctrl;
    logic [NCH-1:0][break_unit_pkg::ADDR_W-1:0]   a_start;
    logic [NCH-1:0][break_unit_pkg::ADDR_W-1:0]   a_end;
    logic [NCH-1:0][break_unit_pkg::ADDR_W-1:0]   a_mask;
    logic [NCH-1:0][break_unit_pkg::DATA_W-1:0]   d_val;
    logic [NCH-1:0][break_unit_pkg::DATA_W-1:0]   d_mask;
    logic [2:0]                                   seq;
    logic                                         running;
    logic                                         brk;
    logic                                         trel;
    logic [2:0]                                   cause;
    logic [31:0]                                  rdata;
    logic                                         rst_hit;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [NCH-1:0] hit;

  //////////////////////////////////////////////////////////////////////////////
  // match channels
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // range is only possible on the first and third channel, and only while the partner is idle
      match_channel #(
        .RANGE_OK ((g % 2) == 0)
      ) u_ch (
        .clk_in         (CLK_IN),
        .rst_b_in       (RST_B_IN),
        .ctrl_in        (st_reg.ctrl[g]),
        .range_block_in (((g % 2) == 0) ?
                         (st_reg.ctrl[(g+1)%NCH][break_unit_pkg::CTL_AMODE_LSB +: 2]
                          != break_unit_pkg::AMODE_OFF) : 1'b0),
        .a_start_in     (st_reg.a_start[g]),
        .a_end_in       (st_reg.a_end[g]),
        .a_mask_in      (st_reg.a_mask[g]),
        .d_val_in       (st_reg.d_val[g]),
        .d_mask_in      (st_reg.d_mask[g]),
        .cyc_in         (BUS_CYC_IN),
        .addr_in        (BUS_ADDR_IN),
        .data_in        (BUS_DATA_IN),
        .wr_in          (BUS_WR_IN),
        .xfer_in        (BUS_XFER_IN),
        .size_in        (BUS_SIZE_IN),
        .hit_out        (hit[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       seq_mode;
    logic       ch1_fire;
    logic       seq_fire;
    logic       ovf_fire;
    logic       to_fire;
    logic       sw_fire;
    logic [2:0] ci;
    logic [2:0] wi;
    st_next = st_reg;
    st_next.trel = 1'b0;
    ch1_fire = 1'b0;
    seq_fire = 1'b0;
    seq_mode = st_reg.emode == break_unit_pkg::EMODE_SEQ1 ||
               st_reg.emode == break_unit_pkg::EMODE_SEQ2 ||
               st_reg.emode == break_unit_pkg::EMODE_SEQ3;
    ci = REG_ADDR_IN[7:5] - 3'h2;
    wi = REG_ADDR_IN[4:2];

    // the reset-point compare is registered like the channel hits so both line up
    st_next.rst_hit = BUS_CYC_IN && st_reg.rstpt_en && BUS_ADDR_IN == st_reg.rstpt;

    // channel one with optional satisfaction counter
    if (st_reg.running && hit[0]) begin
      if (!st_reg.cnt_en) begin
        ch1_fire = 1'b1;
      end else if (st_reg.count_left <= break_unit_pkg::COUNT_RESET) begin
        ch1_fire = 1'b1;
      end else begin
        st_next.count_left = st_reg.count_left - break_unit_pkg::COUNT_RESET;
      end
    end

    // sequence tracker holds across misses
    if (st_reg.running && seq_mode) begin
      case (seq_t'(st_reg.seq))
        SEQ_WAIT4: if (hit[3]) st_next.seq = 3'(SEQ_WAIT3);
        SEQ_WAIT3: if (hit[2]) st_next.seq = 3'(SEQ_WAIT2);
        SEQ_WAIT2: if (hit[1]) st_next.seq = 3'(SEQ_WAIT1);
        SEQ_WAIT1: if (ch1_fire) seq_fire = 1'b1;
        default:   st_next.seq = st_reg.seq;
      endcase
      if (st_reg.rst_hit && !seq_fire) begin
        st_next.seq = (st_reg.emode == break_unit_pkg::EMODE_SEQ3) ? 3'(SEQ_WAIT4) :
                      (st_reg.emode == break_unit_pkg::EMODE_SEQ2) ? 3'(SEQ_WAIT3) : 3'(SEQ_WAIT2);
        st_next.count_left = st_reg.count_set;
      end
    end

    ovf_fire = st_reg.running && st_reg.ovf_en && TRACE_OVF_IN;
    to_fire  = st_reg.running && st_reg.emode == break_unit_pkg::EMODE_TIMEOUT && PERF_TIMEOUT_IN;
    sw_fire  = st_reg.running && st_reg.emode != break_unit_pkg::EMODE_TIMEOUT && SW_BREAK_IN;

    st_next.brk = 1'b0;
    if (RUN_START_IN && !st_reg.running) begin
      st_next.running    = 1'b1;
      st_next.count_left = st_reg.count_set;
      st_next.seq        = (st_reg.emode == break_unit_pkg::EMODE_SEQ3) ? 3'(SEQ_WAIT4) :
                           (st_reg.emode == break_unit_pkg::EMODE_SEQ2) ? 3'(SEQ_WAIT3) :
                           (st_reg.emode == break_unit_pkg::EMODE_SEQ1) ? 3'(SEQ_WAIT2) : 3'(SEQ_IDLE);
    end else if (st_reg.running) begin
      if (HOST_STOP_IN) begin
        st_next.brk   = 1'b1;
        st_next.cause = 3'h1;
        st_next.trel  = TRACE_HALT_IN;
      end else if (seq_mode ? seq_fire : ch1_fire) begin
        st_next.brk   = 1'b1;
        st_next.cause = 3'h2;
      end else if (ovf_fire) begin
        st_next.brk   = 1'b1;
        st_next.cause = 3'h3;
      end else if (to_fire) begin
        st_next.brk   = 1'b1;
        st_next.cause = 3'h4;
      end else if (sw_fire) begin
        st_next.brk   = 1'b1;
        st_next.cause = 3'h5;
      end
      if (st_next.brk) begin
        st_next.running    = 1'b0;
        st_next.seq        = 3'(SEQ_IDLE);
        st_next.count_left = st_reg.count_set;
      end
    end

    // register writes
    if (REG_WR_IN) begin
      if (REG_ADDR_IN == break_unit_pkg::REG_MODE) begin
        st_next.emode    = REG_WDATA_IN[break_unit_pkg::MODE_EMODE_LSB +: 3];
        st_next.ovf_en   = REG_WDATA_IN[break_unit_pkg::MODE_OVFBRK];
        st_next.cnt_en   = REG_WDATA_IN[break_unit_pkg::MODE_CNTEN];
        st_next.rstpt_en = REG_WDATA_IN[break_unit_pkg::MODE_RSTPT_EN];
      end else if (REG_ADDR_IN == break_unit_pkg::REG_COUNT) begin
        // zero is outside the legal span and is taken as one
        st_next.count_set  = (REG_WDATA_IN[15:0] == '0) ? break_unit_pkg::COUNT_RESET : REG_WDATA_IN[15:0];
        st_next.count_left = st_next.count_set;
      end else if (REG_ADDR_IN == break_unit_pkg::REG_RSTPT) begin
        st_next.rstpt = REG_WDATA_IN;
        // slots above the last channel would alias onto the low channels
      end else if (REG_ADDR_IN >= break_unit_pkg::REG_CH_BASE && REG_ADDR_IN[1:0] == 2'h0 && ci < 3'(NCH)) begin
        case (wi)
          break_unit_pkg::CH_CTRL:  st_next.ctrl[ci[1:0]]    = REG_WDATA_IN[break_unit_pkg::CTL_W-1:0];
          break_unit_pkg::CH_ASTRT: st_next.a_start[ci[1:0]] = REG_WDATA_IN;
          break_unit_pkg::CH_AEND:  st_next.a_end[ci[1:0]]   = REG_WDATA_IN;
          break_unit_pkg::CH_AMASK: st_next.a_mask[ci[1:0]]  = REG_WDATA_IN;
          break_unit_pkg::CH_DVAL:  st_next.d_val[ci[1:0]]   = REG_WDATA_IN;
          break_unit_pkg::CH_DMASK: st_next.d_mask[ci[1:0]]  = REG_WDATA_IN;
          default:                  st_next.rdata = st_next.rdata;
        endcase
      end
    end

    // register reads, data in the following cycle; unmapped reads zero
    st_next.rdata = '0;
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == break_unit_pkg::REG_MODE) begin
        st_next.rdata = {25'h0, st_reg.rstpt_en, st_reg.cnt_en, st_reg.ovf_en, 1'b0, st_reg.emode};
      end else if (REG_ADDR_IN == break_unit_pkg::REG_STATUS) begin
        st_next.rdata = {24'h0, st_reg.seq, st_reg.cause, st_reg.brk, st_reg.running};
      end else if (REG_ADDR_IN == break_unit_pkg::REG_COUNT) begin
        st_next.rdata = {st_reg.count_left, st_reg.count_set};
      end else if (REG_ADDR_IN == break_unit_pkg::REG_RSTPT) begin
        st_next.rdata = st_reg.rstpt;
      end else if (REG_ADDR_IN >= break_unit_pkg::REG_CH_BASE && REG_ADDR_IN[1:0] == 2'h0 && ci < 3'(NCH)) begin
        case (wi)
          break_unit_pkg::CH_CTRL:  st_next.rdata = 32'(st_reg.ctrl[ci[1:0]]);
          break_unit_pkg::CH_ASTRT: st_next.rdata = st_reg.a_start[ci[1:0]];
          break_unit_pkg::CH_AEND:  st_next.rdata = st_reg.a_end[ci[1:0]];
          break_unit_pkg::CH_AMASK: st_next.rdata = st_reg.a_mask[ci[1:0]];
          break_unit_pkg::CH_DVAL:  st_next.rdata = st_reg.d_val[ci[1:0]];
          break_unit_pkg::CH_DMASK: st_next.rdata = st_reg.d_mask[ci[1:0]];
          default:                  st_next.rdata = '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_reg            <= '0;
      st_reg.count_set  <= break_unit_pkg::COUNT_RESET;
      st_reg.count_left <= break_unit_pkg::COUNT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA_OUT     = st_reg.rdata;
  assign BREAK_OUT         = st_reg.brk;
  assign TRACE_RELEASE_OUT = st_reg.trel;
  assign RUNNING_OUT       = st_reg.running;

endmodule

// ==== bench/break_unit_monitor.sv ====
`timescale 1ns/1ps
module break_unit_monitor (
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic        RUN_START_IN,
  input wire logic        HOST_STOP_IN,
  input wire logic        TRACE_HALT_IN,
  input wire logic        BREAK_OUT,
  input wire logic        TRACE_RELEASE_OUT,
  input wire logic        RUNNING_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  ////////////////////////////////////////////////////////////////////////////////
  sequence stop_req;
    RUNNING_OUT && HOST_STOP_IN;
  endsequence
  sequence stop_ack;
    BREAK_OUT && !RUNNING_OUT;
  endsequence
  stop_break_a: assert property (stop_req |=> stop_ack)
    else $error("host stop did not halt the run");
  release_on_stop_a: assert property (stop_req ##0 TRACE_HALT_IN |=> TRACE_RELEASE_OUT)
    else $error("trace halt not released on forced stop");
  release_cause_a: assert property (TRACE_RELEASE_OUT |-> BREAK_OUT && $past(TRACE_HALT_IN))
    else $error("trace release without forced break");
  break_pulse_a: assert property (BREAK_OUT |=> !BREAK_OUT)
    else $error("break longer than one cycle");
  break_running_a: assert property (BREAK_OUT |-> $past(RUNNING_OUT) && !RUNNING_OUT)
    else $error("break outside a run");
  run_ends_a: assert property ($fell(RUNNING_OUT) |-> BREAK_OUT)
    else $error("run ended without break");
  run_start_a: assert property (!RUNNING_OUT && RUN_START_IN && !HOST_STOP_IN |=> RUNNING_OUT)
    else $error("run did not start");
  rdata_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
    else $error("read data outside read slot");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind break_unit break_unit_monitor chk_i (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .RUN_START_IN(RUN_START_IN), .HOST_STOP_IN(HOST_STOP_IN), .TRACE_HALT_IN(TRACE_HALT_IN),
  .BREAK_OUT(BREAK_OUT), .TRACE_RELEASE_OUT(TRACE_RELEASE_OUT), .RUNNING_OUT(RUNNING_OUT));

// ==== bench/target_bus_model.sv ====
`timescale 1ns/1ps
// target processor bus: one cycle per call, lines scrambled when idle
module target_bus_model (
  input  wire logic                              clk_in,
  output logic                                   cyc_out,
  output logic [break_unit_pkg::ADDR_W-1:0]      addr_out,
  output logic [break_unit_pkg::DATA_W-1:0]      data_out,
  output logic                                   wr_out,
  output logic                                   xfer_out,
  output logic [1:0]                             size_out
);
  initial begin
    cyc_out = 1'b0;
    addr_out = 32'hffff_ffff;
    data_out = 32'h0;
    wr_out = 1'b0;
    xfer_out = 1'b0;
    size_out = 2'h0;
  end
  task automatic cycle(input logic [31:0] a, input logic w, input logic x);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    addr_out <= a;
    data_out <= 32'h5a5a_0f0f;
    wr_out <= w;
    xfer_out <= x;
    size_out <= break_unit_pkg::SIZE_LONG;
    @(posedge clk_in);
    // inverted leftovers so a stale value never matches by luck
    cyc_out <= 1'b0;
    addr_out <= ~a;
    data_out <= 32'ha5a5_f0f0;
    wr_out <= ~w;
    xfer_out <= ~x;
    size_out <= 2'h0;
  endtask
endmodule

// ==== bench/break_unit_bench.sv ====
`timescale 1ns/1ps
module break_unit_bench;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        run_start = 1'b0;
  logic        trace_halt = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic [31:0] rdata, bus_addr, bus_data;
  logic        bus_cyc, bus_wr, bus_xfer, brk, rel, running;
  logic [1:0]  bus_size;
  int          err_total = 0;
  int          tests_run = 0;
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  target_bus_model bus (.clk_in(clk_in), .cyc_out(bus_cyc), .addr_out(bus_addr), .data_out(bus_data),
    .wr_out(bus_wr), .xfer_out(bus_xfer), .size_out(bus_size));
  break_unit dut (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
    .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata), .RUN_START_IN(run_start),
    .HOST_STOP_IN(ev[3]), .SW_BREAK_IN(ev[2]), .TRACE_HALT_IN(trace_halt), .TRACE_OVF_IN(ev[0]),
    .PERF_TIMEOUT_IN(ev[1]), .BUS_CYC_IN(bus_cyc), .BUS_ADDR_IN(bus_addr), .BUS_DATA_IN(bus_data),
    .BUS_WR_IN(bus_wr), .BUS_XFER_IN(bus_xfer), .BUS_SIZE_IN(bus_size), .BREAK_OUT(brk),
    .TRACE_RELEASE_OUT(rel), .RUNNING_OUT(running));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic fire(input logic [3:0] v);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 4'h0;
  endtask
  task automatic run_go;
    @(posedge clk_in);
    run_start <= 1'b1;
    @(posedge clk_in);
    run_start <= 1'b0;
    #1 chk({31'h0, running}, 32'h1);
  endtask
  // polls just after each edge so a one-cycle pulse is never stepped over
  task automatic expect_break(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      #1 if (brk === 1'b1) seen = 1'b1;
      @(posedge clk_in);
    end
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic halt;
    if (running === 1'b1) fire(4'h8);
    repeat (2) @(posedge clk_in);
  endtask
  function automatic logic [31:0] ch_addr(input int n);
    return 32'h0000_1000 + 32'(n * 16);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] v;
    rd(8'h08, v);
    chk({16'h0, v[15:0]}, 32'h1);
    rd(8'h20, v);
    chk(v, 32'h0);
  endtask
  task automatic t_quals;
    logic [1:0] cls, dr;
    wr(8'h00, 32'h0);
    wr(8'h44, ch_addr(0));
    for (int c = 0; c < 3; c++) begin
      for (int d = 0; d < 3; d++) begin
        cls = c[1:0];
        dr = d[1:0];
        wr(8'h40, {21'h0, dr, cls, 5'h00, 2'h1});
        run_go;
        bus.cycle(ch_addr(0), 1'b0, 1'b1);
        expect_break(cls != break_unit_pkg::CLASS_DATA && dr != break_unit_pkg::DIR_WRITE);
        halt;
      end
    end
    wr(8'h40, 32'h1);
    run_go;
    bus.cycle(ch_addr(1), 1'b1, 1'b0);
    expect_break(1'b0);
    halt;
  endtask
  task automatic t_count;
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h3);
    run_go;
    repeat (2) bus.cycle(ch_addr(0), 1'b1, 1'b0);
    expect_break(1'b0);
    bus.cycle(ch_addr(0), 1'b1, 1'b0);
    expect_break(1'b1);
    wr(8'h00, 32'h0);
    run_go;
    bus.cycle(ch_addr(0), 1'b1, 1'b0);
    expect_break(1'b1);
    wr(8'h08, 32'h1);
  endtask
  task automatic t_seq;
    for (int n = 0; n < 4; n++) begin
      wr(8'h40 + 8'(n * 32), 32'h1);
      wr(8'h44 + 8'(n * 32), ch_addr(n));
    end
    wr(8'h0c, 32'h0000_2000);
    for (int m = 1; m < 4; m++) begin
      wr(8'h00, 32'h40 | 32'(m));
      run_go;
      bus.cycle(ch_addr(0), 1'b1, 1'b0);
      expect_break(1'b0);
      for (int k = m; k > 0; k--) bus.cycle(ch_addr(k), 1'b1, 1'b0);
      bus.cycle(32'h0000_2000, 1'b1, 1'b0);
      bus.cycle(ch_addr(0), 1'b1, 1'b0);
      expect_break(1'b0);
      for (int k = m; k >= 0; k--) bus.cycle(ch_addr(k), 1'b1, 1'b0);
      expect_break(1'b1);
      halt;
    end
    wr(8'h00, 32'h40);
    run_go;
    bus.cycle(32'h0000_2000, 1'b1, 1'b0);
    bus.cycle(ch_addr(0), 1'b1, 1'b0);
    expect_break(1'b1);
  endtask
  task automatic t_events;
    for (int h = 0; h < 2; h++) begin
      run_go;
      trace_halt <= h[0];
      fire(4'h8);
      #1 chk({30'h0, brk, rel}, {30'h0, 1'b1, h[0]});
      trace_halt <= 1'b0;
    end
    wr(8'h00, 32'h10);
    run_go;
    fire(4'h1);
    expect_break(1'b1);
    wr(8'h00, 32'h0);
    run_go;
    fire(4'h4);
    expect_break(1'b1);
    wr(8'h00, 32'h4);
    run_go;
    fire(4'h4);
    expect_break(1'b0);
    fire(4'h2);
    expect_break(1'b1);
  endtask
  task automatic t_fields;
    wr(8'h00, 32'h0);
    wr(8'h4c, 32'h0000_00ff);
    wr(8'h40, 32'h5);
    run_go;
    bus.cycle(32'h0000_10ab, 1'b1, 1'b0);
    expect_break(1'b1);
    wr(8'h40, 32'h21);
    run_go;
    bus.cycle(ch_addr(0), 1'b1, 1'b0);
    expect_break(1'b0);
    halt;
    wr(8'h40, 32'h2);
    wr(8'h48, 32'h0000_10ff);
    run_go;
    bus.cycle(32'h0000_1080, 1'b1, 1'b0);
    expect_break(1'b0);
    halt;
    wr(8'h60, 32'h0);
    run_go;
    bus.cycle(32'h0000_1080, 1'b1, 1'b0);
    expect_break(1'b1);
    // channel two now hits every cycle: a kept sequence would break on the next run
    wr(8'h00, 32'h1);
    run_go;
    bus.cycle(32'h0000_3000, 1'b1, 1'b0);
    halt;
    run_go;
    bus.cycle(32'h0000_1080, 1'b1, 1'b0);
    expect_break(1'b0);
    halt;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs;
    t_quals;
    t_count;
    t_seq;
    t_events;
    t_fields;
    stop_test;
  end
  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    stop_test;
  end
endmodule
